// ===== nand_timing_pkg.sv
// Package for the NAND interface timing block: register offsets, field
// positions, reset values and the sequencer state type.
// Assumes a 32-bit APB slave whose byte offsets are the constants below.
package nand_timing_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] FLASH_CONTROL_OFS     = 8'h00;
  localparam logic [7:0] TIMING_PRIMARY_OFS    = 8'h04;
  localparam logic [7:0] TIMING_READ_OFS       = 8'h08;
  localparam logic [7:0] SEQ_COMMAND_OFS       = 8'h0C;
  localparam logic [7:0] SEQ_STATUS_OFS        = 8'h10;
  localparam logic [7:0] READ_DATA_OFS         = 8'h14;

  // ==========================================================================
  // Reset values and writable-bit masks
  // ==========================================================================
  localparam logic [31:0] FLASH_CONTROL_RST    = 32'h0002_0FFF;
  localparam logic [31:0] FLASH_CONTROL_MASK   = 32'hFFFF_DFFF;
  localparam logic [31:0] TIMING_PRIMARY_RST   = 32'h0000_0000;
  localparam logic [31:0] TIMING_PRIMARY_MASK  = 32'h003F_3F7F;
  localparam logic [31:0] TIMING_READ_RST      = 32'h0000_0000;
  localparam logic [31:0] TIMING_READ_MASK     = 32'hFFFF_00FF;

  // ==========================================================================
  // Field positions, primary timing register
  // ==========================================================================
  localparam int HOLD_LSB       = 19;
  localparam int SETUP_LSB      = 16;
  localparam int WR_HIGH_LSB    = 11;
  localparam int WR_LOW_LSB     = 8;
  localparam int EXT_RD_LOW_BIT = 6;
  localparam int RD_HIGH_LSB    = 3;
  localparam int RD_LOW_LSB     = 0;

  // ==========================================================================
  // Field positions, read timing register
  // ==========================================================================
  localparam int READ_WAIT_LSB  = 16;
  localparam int WHR_LSB        = 4;
  localparam int AR_LSB         = 0;

  // ==========================================================================
  // Sequencer command and status fields
  // ==========================================================================
  localparam int CMD_OP_LSB     = 8;
  localparam int CMD_CS_BIT     = 10;
  localparam int CMD_ADDR_BIT   = 11;
  localparam int CS0_DONE_BIT   = 8;
  localparam int CS1_DONE_BIT   = 7;
  localparam int BUSY_BIT       = 16;
  localparam int RB_LEVEL_BIT   = 17;

  // Operation codes written to the command register.
  localparam logic [1:0] OP_WRITE_ONLY  = 2'h0;
  localparam logic [1:0] OP_PAGE_READ   = 2'h1;
  localparam logic [1:0] OP_STATUS_READ = 2'h2;
  localparam logic [1:0] OP_ID_READ     = 2'h3;

  // Controller clock rates the timing fields count in; informative only.
  localparam int CLK_FAST_MHZ   = 156;
  localparam int CLK_SLOW_MHZ   = 104;

  localparam int TIMER_W        = 18;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_WR_LOW,
    ST_HOLD,
    ST_GAP,
    ST_RD_LOW,
    ST_RD_HIGH
  } seq_state_t;

endpackage

// ===== nand_phase_timer.sv
// Phase timer for the NAND strobe sequencer: counts a loaded number of
// controller clock periods and flags the last one.
// Assumes the loader gives a value of one or more.
`timescale 1ns/1ps

module nand_phase_timer
  import nand_timing_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  input  wire logic               load,
  input  wire logic [TIMER_W-1:0] load_value,
  input  wire logic               pause,
  output logic                    last_cycle
);

  typedef struct packed {
    logic [TIMER_W-1:0] count;
  } timer_state_t;

  timer_state_t state_q;
  timer_state_t state_d;

  // The final cycle only counts when not paused, so a pause stretches it.
  assign last_cycle = (state_q.count == TIMER_W'(1)) && !pause;

  // ==========================================================================
  // Next count
  // ==========================================================================
  // Load wins over counting; a paused timer holds its value.
  always_comb begin
    state_d = state_q;
    if (load) begin
      state_d.count = load_value;
    end else if (!pause && state_q.count != '0) begin
      state_d.count = state_q.count - TIMER_W'(1);
    end
  end

  // Register the count; a low clock enable freezes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

endmodule

// ===== nand_interface_timing.sv
// NAND flash interface timing block: APB register file plus the strobe
// sequencer that drives selects, latch enables and strobes to the flash.
// Assumes pins and APB signals are synchronous to pclk.
//
// Overview of operation
// - Every timing field counts controller clock periods.
// - Controller clock may run at 156 or 104 MHz; fields count its periods at either rate.
// - Both chip selects share one set of timing fields.
// - Hold field keeps selects and latch enables after write strobe rises.
// - Setup field drives selects and latch enables before write strobe falls.
// - Second timing register times page, status and ID reads.
// - Page read gap is hold plus one plus read wait plus two.
// - Ready/busy input is not watched to end the read wait.
// - Write-high-to-read field sets status and ID read gap.
// - Status gap is hold plus latch field plus two, else field plus one.
// - Gaps are minimums and stretch while the shared bus is lost.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps

module nand_interface_timing
  import nand_timing_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shared_data_bus_granted,
  input  wire logic        ready_busy_n,
  input  wire logic [7:0]  flash_data_in,
  output logic [7:0]       flash_data_out,
  output logic             flash_data_oe,
  output logic             flash_select0_n,
  output logic             flash_select1_n,
  output logic             address_latch_enable,
  output logic             command_latch_enable,
  output logic             write_strobe_n,
  output logic             read_strobe_n,
  output logic             event_request
);

  typedef struct packed {
    logic [31:0] control;
    logic [31:0] timing0;
    logic [31:0] timing1;
    logic [1:0]  op;
    logic        cs;
    logic        addr_cycle;
    logic [1:0]  done_flags;
    logic [7:0]  read_data;
    seq_state_t  seq;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic [7:0]  data_out;
    logic        data_oe;
    logic        sel0_n;
    logic        sel1_n;
    logic        ale;
    logic        cle;
    logic        we_n;
    logic        re_n;
    logic        irq;
  } blk_state_t;

  blk_state_t           state_q;
  blk_state_t           state_d;
  logic                 tmr_load;
  logic [TIMER_W-1:0]   tmr_value;
  logic                 tmr_pause;
  logic                 tmr_last;

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  // Offset decode, shared by the read and write paths.
  function automatic logic reg_mapped(input logic [7:0] a);
    if (a == FLASH_CONTROL_OFS) begin
      reg_mapped = 1'b1;
    end else if (a == TIMING_PRIMARY_OFS) begin
      reg_mapped = 1'b1;
    end else if (a == TIMING_READ_OFS) begin
      reg_mapped = 1'b1;
    end else if (a == SEQ_COMMAND_OFS) begin
      reg_mapped = 1'b1;
    end else if (a == SEQ_STATUS_OFS) begin
      reg_mapped = 1'b1;
    end else if (a == READ_DATA_OFS) begin
      reg_mapped = 1'b1;
    end else begin
      reg_mapped = 1'b0;
    end
  endfunction

  // Widen a timing field to timer width and add the caller's extra periods (zero, one or two).
  function automatic logic [TIMER_W-1:0] periods(input logic [15:0] field,
                                                 input logic [2:0]  extra);
    periods = TIMER_W'(field) + TIMER_W'(extra);
  endfunction

  // ==========================================================================
  // Timing fields
  // ==========================================================================
  // periods of pclk
  logic [2:0]  f_hold;
  logic [2:0]  f_setup;
  logic [2:0]  f_wr_high;
  logic [2:0]  f_wr_low;
  logic [3:0]  f_rd_low;
  logic [2:0]  f_rd_high;
  logic [15:0] f_read_wait;
  logic [3:0]  f_whr;
  logic [3:0]  f_ar;
  logic [4:0]  latch_sum;

  assign f_hold      = state_q.timing0[HOLD_LSB +: 3];
  assign f_setup     = state_q.timing0[SETUP_LSB +: 3];
  assign f_wr_high   = state_q.timing0[WR_HIGH_LSB +: 3];
  assign f_wr_low    = state_q.timing0[WR_LOW_LSB +: 3];
  assign f_rd_low    = {state_q.timing0[EXT_RD_LOW_BIT], state_q.timing0[RD_LOW_LSB +: 3]};
  assign f_rd_high   = state_q.timing0[RD_HIGH_LSB +: 3];
  assign f_read_wait = state_q.timing1[READ_WAIT_LSB +: 16];
  assign f_whr       = state_q.timing1[WHR_LSB +: 4];
  assign f_ar        = state_q.timing1[AR_LSB +: 4];
  assign latch_sum   = {1'b0, f_ar} + {2'b00, f_hold};

  assign tmr_pause = (state_q.seq == ST_GAP) && !shared_data_bus_granted;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // One process computes the bus slave, the event flags and the sequencer.
  always_comb begin
    logic        access;
    logic        wr_hit;
    logic [1:0]  set_flags;
    logic [31:0] rd_word;
    access    = 1'b0;
    wr_hit    = 1'b0;
    set_flags = 2'b00;
    rd_word   = 32'h0000_0000;
    state_d   = state_q;
    tmr_load  = 1'b0;
    tmr_value = TIMER_W'(1);

    // The answer is registered in the setup cycle, so pready rises in the
    // first access cycle and every transfer has zero wait states.
    access = psel && penable && state_q.ready;
    state_d.ready = psel && !penable;
    state_d.slverr = psel && !penable && !reg_mapped(paddr);
    wr_hit = access && pwrite;

    // Read mux, sampled in the setup cycle; reserved bits read as zero.
    if (paddr == FLASH_CONTROL_OFS) begin
      rd_word = state_q.control;
    end else if (paddr == TIMING_PRIMARY_OFS) begin
      rd_word = state_q.timing0;
    end else if (paddr == TIMING_READ_OFS) begin
      rd_word = state_q.timing1;
    end else if (paddr == SEQ_STATUS_OFS) begin
      rd_word[CS0_DONE_BIT] = state_q.done_flags[0];
      rd_word[CS1_DONE_BIT] = state_q.done_flags[1];
      rd_word[BUSY_BIT]     = state_q.seq != ST_IDLE;
      rd_word[RB_LEVEL_BIT] = ready_busy_n;
    end else if (paddr == READ_DATA_OFS) begin
      rd_word[7:0] = state_q.read_data;
    end else begin
      rd_word = 32'h0000_0000;
    end
    if (psel && !penable) begin
      state_d.rdata = rd_word;
    end

    if (wr_hit && paddr == FLASH_CONTROL_OFS) begin
      state_d.control = pwdata & FLASH_CONTROL_MASK;
    end else if (wr_hit && paddr == TIMING_PRIMARY_OFS) begin
      state_d.timing0 = pwdata & TIMING_PRIMARY_MASK;
    end else if (wr_hit && paddr == TIMING_READ_OFS) begin
      state_d.timing1 = pwdata & TIMING_READ_MASK;
    end

    // Sequencer. A command written while busy is ignored.
    case (state_q.seq)
      ST_IDLE: begin
        if (wr_hit && paddr == SEQ_COMMAND_OFS) begin
          state_d.op         = pwdata[CMD_OP_LSB +: 2];
          state_d.cs         = pwdata[CMD_CS_BIT];
          state_d.addr_cycle = pwdata[CMD_ADDR_BIT];
          state_d.data_out   = pwdata[7:0];
          state_d.data_oe    = 1'b1;
          state_d.sel0_n     = pwdata[CMD_CS_BIT];
          state_d.sel1_n     = !pwdata[CMD_CS_BIT];
          state_d.ale        = pwdata[CMD_ADDR_BIT];
          state_d.cle        = !pwdata[CMD_ADDR_BIT];
          state_d.seq        = ST_SETUP;
          tmr_load  = 1'b1;
          tmr_value = periods({13'h0000, f_setup}, 3'd1);
        end
      end
      ST_SETUP: begin
        if (tmr_last) begin
          state_d.we_n = 1'b0;
          state_d.seq  = ST_WR_LOW;
          tmr_load  = 1'b1;
          tmr_value = periods({13'h0000, f_wr_low}, 3'd1);
        end
      end
      ST_WR_LOW: begin
        if (tmr_last) begin
          state_d.we_n = 1'b1;
          state_d.seq  = ST_HOLD;
          tmr_load = 1'b1;
          if (state_q.op == OP_WRITE_ONLY && f_wr_high > f_hold) begin
            tmr_value = periods({13'h0000, f_wr_high}, 3'd1);
          end else begin
            tmr_value = periods({13'h0000, f_hold}, 3'd1);
          end
        end
      end
      ST_HOLD: begin
        if (tmr_last) begin
          state_d.ale     = 1'b0;
          state_d.cle     = 1'b0;
          state_d.data_oe = 1'b0;
          tmr_load        = 1'b1;
          if (state_q.op == OP_WRITE_ONLY) begin
            state_d.sel0_n = 1'b1;
            state_d.sel1_n = 1'b1;
            state_d.seq    = ST_IDLE;
            set_flags[state_q.cs] = 1'b1;
          end else if (state_q.op == OP_PAGE_READ) begin
            state_d.seq = ST_GAP;
            tmr_value = periods(f_read_wait, 3'd2);
          end else if ({1'b0, latch_sum} >= {2'b00, f_whr}) begin
            state_d.seq = ST_GAP;
            tmr_value = periods({12'h000, f_ar}, 3'd1);
          end else begin
            state_d.seq = ST_GAP;
            tmr_value = periods({12'h000, f_whr - {1'b0, f_hold}}, 3'd0);
          end
        end
      end
      ST_GAP: begin
        if (tmr_last) begin
          state_d.re_n = 1'b0;
          state_d.seq  = ST_RD_LOW;
          tmr_load  = 1'b1;
          tmr_value = periods({12'h000, f_rd_low}, 3'd1);
        end
      end
      ST_RD_LOW: begin
        if (tmr_last) begin
          state_d.read_data = flash_data_in;
          state_d.re_n      = 1'b1;
          state_d.seq       = ST_RD_HIGH;
          tmr_load  = 1'b1;
          tmr_value = periods({13'h0000, f_rd_high}, 3'd1);
        end
      end
      ST_RD_HIGH: begin
        if (tmr_last) begin
          state_d.sel0_n = 1'b1;
          state_d.sel1_n = 1'b1;
          state_d.seq    = ST_IDLE;
          set_flags[state_q.cs] = 1'b1;
        end
      end
      default: begin
        state_d.seq = ST_IDLE;
      end
    endcase

    // Done flags clear on writing one; a new completion wins over the clear.
    if (wr_hit && paddr == SEQ_STATUS_OFS) begin
      state_d.done_flags[0] = state_q.done_flags[0] & ~pwdata[CS0_DONE_BIT];
      state_d.done_flags[1] = state_q.done_flags[1] & ~pwdata[CS1_DONE_BIT];
    end
    state_d.done_flags = state_d.done_flags | set_flags;

    state_d.irq = (state_q.done_flags[0] & ~state_q.control[CS0_DONE_BIT])
                | (state_q.done_flags[1] & ~state_q.control[CS1_DONE_BIT]);
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // All state but the phase timer's count is held here; a low clock enable freezes everything.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q          <= '0;
      state_q.control  <= FLASH_CONTROL_RST;
      state_q.timing0  <= TIMING_PRIMARY_RST;
      state_q.timing1  <= TIMING_READ_RST;
      state_q.seq      <= ST_IDLE;
      state_q.sel0_n   <= 1'b1;
      state_q.sel1_n   <= 1'b1;
      state_q.we_n     <= 1'b1;
      state_q.re_n     <= 1'b1;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // The phase timer is kept apart; its pause input is raised only in ST_GAP, so only the read gap stretches.
  nand_phase_timer u_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .load       (tmr_load),
    .load_value (tmr_value),
    .pause      (tmr_pause),
    .last_cycle (tmr_last)
  );

  // ==========================================================================
  // Outputs, each straight from the state register
  // ==========================================================================
  assign prdata               = state_q.rdata;
  assign pready               = state_q.ready;
  assign pslverr              = state_q.slverr;
  assign flash_data_out       = state_q.data_out;
  assign flash_data_oe        = state_q.data_oe;
  assign flash_select0_n      = state_q.sel0_n;
  assign flash_select1_n      = state_q.sel1_n;
  assign address_latch_enable = state_q.ale;
  assign command_latch_enable = state_q.cle;
  assign write_strobe_n       = state_q.we_n;
  assign read_strobe_n        = state_q.re_n;
  assign event_request        = state_q.irq;

endmodule

// ===== nand_timing_monitor.sv
// Checker for the NAND timing block: pin ordering and the APB answer.
// Assumes it is bound to nand_interface_timing, with pclk as its one clock.
`timescale 1ns/1ps

module nand_timing_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic shared_data_bus_granted,
  input wire logic flash_select0_n,
  input wire logic flash_select1_n,
  input wire logic address_latch_enable,
  input wire logic command_latch_enable,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n
);
  // ==========================================================================
  // Pin relations
  // ==========================================================================
  // One clock domain, so clocking and reset are given once for all.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_one_select: assert property (flash_select0_n || flash_select1_n)
    else $error("Both flash selects are low together.");
  a_we_in_select: assert property (!write_strobe_n |-> !(flash_select0_n && flash_select1_n))
    else $error("Write strobe low with no select.");
  a_setup_before_we: assert property ($fell(write_strobe_n) |->
    !($past(flash_select0_n) && $past(flash_select1_n)))
    else $error("Select not set up before write strobe fell.");
  a_hold_after_we: assert property ($rose(write_strobe_n) |->
    (address_latch_enable || command_latch_enable) && !(flash_select0_n && flash_select1_n))
    else $error("Latch enable or select dropped with the write strobe.");
  a_strobes_apart: assert property (write_strobe_n || read_strobe_n)
    else $error("Write and read strobes low together.");
  a_gap_before_re: assert property ($fell(read_strobe_n) |->
    $past(write_strobe_n) && $past(write_strobe_n, 2))
    else $error("Read strobe fell too soon after the write strobe.");
  a_latch_off_read: assert property (!read_strobe_n |->
    !(address_latch_enable || command_latch_enable))
    else $error("Latch enable high while read strobe low.");
  a_grant_before_re: assert property ($fell(read_strobe_n) |-> $past(shared_data_bus_granted))
    else $error("Read strobe fell while the shared bus was lost.");
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("APB answer not a one-cycle pulse after setup.");
endmodule

bind nand_interface_timing nand_timing_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready,
  .shared_data_bus_granted, .flash_select0_n, .flash_select1_n, .address_latch_enable,
  .command_latch_enable, .write_strobe_n, .read_strobe_n);

// ===== nand_flash_model.sv
// Behavioural NAND flash device for the timing block's far side.
// Assumes one shared model answers both selects with the same data.
`timescale 1ns/1ps

module nand_flash_model (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       flash_select0_n,
  input wire logic       flash_select1_n,
  input wire logic       command_latch_enable,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic       flash_data_oe,
  input wire logic [7:0] flash_data_out,
  output logic [7:0]     flash_data_in,
  output logic           ready_busy_n
);
  logic [7:0] last_q;
  logic [6:0] busy_q;

  // ==========================================================================
  // Latch and busy timer
  // ==========================================================================
  // busy spans reads: busy outlasts the read so the block must not wait on it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 8'h00;
      busy_q <= 7'h00;
    end else begin
      if (!write_strobe_n && flash_data_oe) begin
        last_q <= flash_data_out;
      end
      if (!write_strobe_n && command_latch_enable) begin
        busy_q <= 7'h3C;
      end else if (busy_q != 7'h00) begin
        busy_q <= busy_q - 7'h01;
      end
    end
  end

  assign ready_busy_n = (busy_q == 7'h00);
  // Released bus shows the inverse, so a late capture cannot pass by luck.
  assign flash_data_in = (!read_strobe_n && !(flash_select0_n && flash_select1_n)) ?
                         (last_q ^ 8'h5A) : ~(last_q ^ 8'h5A);
endmodule

// ===== nand_interface_timing_bench.sv
// Self-checking bench for the NAND timing block over APB.
// Assumes the package offsets and a one-clock design with clk_en held high.
`timescale 1ns/1ps

module nand_interface_timing_bench;
  import nand_timing_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        shared_data_bus_granted = 1, pready, pslverr, flash_data_oe, event_request;
  logic [7:0]  paddr = 0, flash_data_in, flash_data_out;
  logic [31:0] pwdata = 0, prdata;
  logic        flash_select0_n, flash_select1_n, address_latch_enable, command_latch_enable;
  logic        write_strobe_n, read_strobe_n, ready_busy_n, last_err;
  logic        p_sel = 1, p_we = 1, p_re = 1, p_lat = 0;
  int          error_cnt, total_checks, cyc, t_sel, t_wf, t_wr, t_lf, t_rf;

  nand_interface_timing dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .shared_data_bus_granted, .ready_busy_n, .flash_data_in,
    .flash_data_out, .flash_data_oe, .flash_select0_n, .flash_select1_n, .address_latch_enable,
    .command_latch_enable, .write_strobe_n, .read_strobe_n, .event_request);
  nand_flash_model u_flash (.pclk, .presetn, .flash_select0_n, .flash_select1_n,
    .command_latch_enable, .write_strobe_n, .read_strobe_n, .flash_data_oe, .flash_data_out,
    .flash_data_in, .ready_busy_n);

  // ==========================================================================
  // Clock, edge stamps and timeout
  // ==========================================================================
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // Stamps use pre-edge values, so every gap is a whole number of periods.
  always @(posedge pclk) begin
    cyc++;
    if (p_sel && !(flash_select0_n && flash_select1_n)) t_sel = cyc;
    if (p_we && !write_strobe_n) t_wf = cyc;
    if (!p_we && write_strobe_n) t_wr = cyc;
    if (p_lat && !(address_latch_enable || command_latch_enable)) t_lf = cyc;
    if (p_re && !read_strobe_n) t_rf = cyc;
    p_sel = flash_select0_n && flash_select1_n;
    p_we = write_strobe_n;
    p_re = read_strobe_n;
    p_lat = address_latch_enable || command_latch_enable;
    if (cyc > 6000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer however long it takes; only the bench timeout ends it.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Issues one command or address byte, then polls busy so the next command is legal.
  task automatic cmd(input logic [1:0] op, input logic cs, input logic [7:0] b,
                     input logic al = 1'b0);
    logic [31:0] r;
    int n;
    apb(1'b1, SEQ_COMMAND_OFS, {20'h0, al, cs, op, b}, r);
    n = 0;
    do begin
      apb(1'b0, SEQ_STATUS_OFS, 32'h0, r);
      n++;
    end while (r[BUSY_BIT] !== 1'b0 && n < 100);
    chk(r[BUSY_BIT], 1'b0);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs;
    logic [7:0]  a [3] = '{FLASH_CONTROL_OFS, TIMING_PRIMARY_OFS, TIMING_READ_OFS};
    logic [31:0] rv [3] = '{FLASH_CONTROL_RST, TIMING_PRIMARY_RST, TIMING_READ_RST};
    logic [31:0] mk [3] = '{FLASH_CONTROL_MASK, TIMING_PRIMARY_MASK, TIMING_READ_MASK};
    logic [31:0] r;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, a[i], 32'h0, r);
      chk(r, rv[i]);
      apb(1'b1, a[i], 32'hFFFF_FFFF, r);
      apb(1'b0, a[i], 32'h0, r);
      chk(r, mk[i]);
    end
    apb(1'b1, 8'h3C, 32'hFFFF_FFFF, r);
    chk(last_err, 1'b1);
  endtask

  task automatic t_write;
    logic [31:0] r;
    apb(1'b1, FLASH_CONTROL_OFS, FLASH_CONTROL_RST & ~(32'h1 << CS0_DONE_BIT), r);
    apb(1'b1, TIMING_PRIMARY_OFS, (32'h2 << HOLD_LSB) | (32'h3 << SETUP_LSB) | (32'h2 << WR_LOW_LSB), r);
    cmd(OP_WRITE_ONLY, 1'b0, 8'hA3);
    chk(t_wf - t_sel, 4);
    chk(t_wr - t_wf, 3);
    chk(t_lf - t_wr, 3);
    // An address byte with a write-high field above hold takes the longer phase.
    apb(1'b1, TIMING_PRIMARY_OFS, (32'h1 << HOLD_LSB) | (32'h4 << WR_HIGH_LSB), r);
    cmd(OP_WRITE_ONLY, 1'b0, 8'h00, 1'b1);
    chk(t_wf - t_sel, 1);
    chk(t_lf - t_wr, 5);
    chk(event_request, 1'b1);
    apb(1'b1, SEQ_STATUS_OFS, 32'h1 << CS0_DONE_BIT, r);
    repeat (2) @(posedge pclk);
    chk(event_request, 1'b0);
  endtask

  task automatic t_reads;
    logic [31:0] tr [2] = '{(32'h2 << WHR_LSB) | (32'h3 << AR_LSB), (32'h9 << WHR_LSB) | 32'h1};
    int          ex [2] = '{6, 10};
    logic [31:0] r;
    apb(1'b1, TIMING_PRIMARY_OFS, 32'h1 << HOLD_LSB, r);
    apb(1'b1, TIMING_READ_OFS, 32'h5 << READ_WAIT_LSB, r);
    cmd(OP_PAGE_READ, 1'b1, 8'h30);
    chk(t_rf - t_wr, 9);
    chk(ready_busy_n, 1'b0);
    apb(1'b0, READ_DATA_OFS, 32'h0, r);
    chk(r[7:0], 8'h30 ^ 8'h5A);
    apb(1'b0, SEQ_STATUS_OFS, 32'h0, r);
    chk({r[RB_LEVEL_BIT], r[CS1_DONE_BIT]}, 2'b01);
    chk(event_request, 1'b0);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, TIMING_READ_OFS, tr[i], r);
      cmd(i ? OP_ID_READ : OP_STATUS_READ, 1'b0, 8'h70);
      chk(t_rf - t_wr, ex[i]);
    end
    // Three paused gap edges stretch the plain 10-period gap to 13.
    shared_data_bus_granted <= 1'b0;
    fork
      cmd(OP_STATUS_READ, 1'b0, 8'h70);
      begin
        @(posedge write_strobe_n);
        repeat (5) @(posedge pclk);
        shared_data_bus_granted <= 1'b1;
      end
    join
    chk(t_rf - t_wr, 13);
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_write();
    t_reads();
    end_sim();
  end
endmodule
